// >>> hdl/mla_pkg.sv
// What this block does
// - A packet is sent by raising RTS, waiting for CTS, sending it, then waiting for a response.
// - Every node watches all received traffic and picks out packets whose address is its own.
// - A packet accepted as our own is passed onward with the route it carries.
// - Line access is shared by time division set by the node count and this node's priority.
// - Node count and time slice are the same on every node so all derive one slot schedule.
// - The priority is unique on the line and lies between one and the node count inclusive.
// - The time slice should be four character times plus the worst RTS to CTS delay, rounded up.
// - The time slice should never be set below five hundredths of a second.
// - In half duplex and two wire modes the block ignores characters echoed back while it is sending.
// - In point to point driver mode the transmitter and receiver are both enabled at all times.
// - In half duplex mode the transmitter stays enabled and the receiver is off while sending.
// - In two wire mode the transmit driver follows CTS and the receiver is off while sending.
package mla_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SLICE_UNIT_NS = 10_000_000;
   localparam int unsigned SLICE_UNIT_CYC = (SLICE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // -----------------------------------------------------------------
   // Configuration limits and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] SLICE_MIN = 8'h05;
   localparam logic [7:0] PRIO_MIN = 8'h01;
   localparam logic [7:0] SLOT_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] POS_ADDR = 2'h0;
   localparam logic [1:0] POS_HOP = 2'h1;
   localparam logic [1:0] POS_DATA = 2'h2;
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MLA_POINT_TO_POINT_DRIVER = 2'h0,
      MLA_HALF_DUPLEX_DRIVER = 2'h1,
      MLA_TWO_WIRE_DRIVER = 2'h2
   } mla_drv_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RTS = 4'h2,
      ST_SEND = 4'h4,
      ST_RESP = 4'h8
   } mla_st_t;
endpackage : mla_pkg

// >>> hdl/mla_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mla_slot_timer
   import mla_pkg::*;
#(
   parameter int unsigned TICK_CYC = SLICE_UNIT_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_node_count,
   input wire logic [7:0] i_time_slice,
   output logic [7:0] o_slot,
   output logic o_slot_start
);
   logic [31:0] pre_r;
   logic [31:0] pre_nxt;
   logic [7:0] slc_r;
   logic [7:0] slc_nxt;
   logic [7:0] slot_r;
   logic [7:0] slot_nxt;
   logic start_r;
   logic start_nxt;

   always_comb begin
      pre_nxt = pre_r + 32'h1;
      slc_nxt = slc_r;
      slot_nxt = slot_r;
      start_nxt = 1'b0;
      if (pre_r >= TICK_CYC - 32'h1) begin
         pre_nxt = '0;
         slc_nxt = slc_r + 8'h01;
         if (slc_nxt >= i_time_slice) begin
            slc_nxt = BYTE_RST;
            start_nxt = 1'b1;
            slot_nxt = (slot_r >= i_node_count) ? PRIO_MIN : slot_r + 8'h01;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pre_r <= '0;
         slc_r <= BYTE_RST;
         slot_r <= SLOT_RST;
         start_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         slc_r <= slc_nxt;
         slot_r <= slot_nxt;
         start_r <= start_nxt;
      end
   end

   assign o_slot = slot_r;
   assign o_slot_start = start_r;
endmodule : mla_slot_timer
`default_nettype wire

// >>> hdl/mla_multidrop_line_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module mla_multidrop_line_arbiter
   import mla_pkg::*;
#(
   parameter int unsigned TICK_CYC = SLICE_UNIT_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_node_addr,
   input wire logic [7:0] i_node_count,
   input wire logic [7:0] i_node_prio,
   input wire logic [7:0] i_time_slice,
   input wire logic [1:0] i_drv_mode,
   input wire logic i_cts,
   output logic o_rts,
   output logic o_tx_drv_en,
   output logic o_rx_en,
   input wire logic i_pkt_valid,
   input wire logic [7:0] i_pkt_data,
   input wire logic i_pkt_last,
   output logic o_pkt_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_last,
   output logic o_fwd_valid,
   output logic [7:0] o_fwd_data,
   output logic o_fwd_last,
   output logic [7:0] o_fwd_hop,
   output logic o_resp_ok,
   output logic o_resp_timeout,
   output logic o_cfg_err,
   output logic o_slice_warn,
   output logic [7:0] o_slot
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic cts_m_r;
   logic cts_s_r;
   logic slot_start;
   logic [7:0] slot;
   logic my_slot;
   logic cfg_err_r;
   logic cfg_err_nxt;
   logic warn_r;
   logic warn_nxt;
   mla_st_t st_r;
   mla_st_t st_nxt;
   logic txv_r;
   logic txv_nxt;
   logic [7:0] txd_r;
   logic [7:0] txd_nxt;
   logic txl_r;
   logic txl_nxt;
   logic tx_go;
   logic ok_r;
   logic ok_nxt;
   logic to_r;
   logic to_nxt;
   logic sending;
   logic rx_acc;
   logic resp_hit;
   logic [1:0] pos_r;
   logic [1:0] pos_nxt;
   logic match_r;
   logic match_nxt;
   logic fv_r;
   logic fv_nxt;
   logic [7:0] fd_r;
   logic [7:0] fd_nxt;
   logic fl_r;
   logic fl_nxt;
   logic [7:0] hop_r;
   logic [7:0] hop_nxt;

   // -----------------------------------------------------------------
   // CTS synchroniser and slot schedule
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cts_m_r <= 1'b0;
         cts_s_r <= 1'b0;
      end else begin
         cts_m_r <= i_cts;
         cts_s_r <= cts_m_r;
      end
   end

   mla_slot_timer #(
      .TICK_CYC(TICK_CYC)
   ) u_slot (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_node_count(i_node_count),
      .i_time_slice(i_time_slice),
      .o_slot(slot),
      .o_slot_start(slot_start)
   );

   assign my_slot = slot_start && (slot == i_node_prio);

   // -----------------------------------------------------------------
   // Configuration checks
   // -----------------------------------------------------------------
   always_comb begin
      cfg_err_nxt = (i_node_prio < PRIO_MIN) || (i_node_prio > i_node_count);
      warn_nxt = (i_time_slice < SLICE_MIN);
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_err_r <= 1'b1;
         warn_r <= 1'b0;
      end else begin
         cfg_err_r <= cfg_err_nxt;
         warn_r <= warn_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Transmit sequence
   // -----------------------------------------------------------------
   assign tx_go = txv_r && i_tx_ready;
   assign o_pkt_ready = (st_r == ST_SEND) && !(txv_r && txl_r) && (!txv_r || i_tx_ready);

   always_comb begin
      st_nxt = st_r;
      txv_nxt = txv_r;
      txd_nxt = txd_r;
      txl_nxt = txl_r;
      ok_nxt = 1'b0;
      to_nxt = 1'b0;
      if (tx_go) begin
         txv_nxt = 1'b0;
      end
      if (o_pkt_ready && i_pkt_valid) begin
         txv_nxt = 1'b1;
         txd_nxt = i_pkt_data;
         txl_nxt = i_pkt_last;
      end
      unique case (st_r)
         ST_IDLE: begin
            if (i_pkt_valid && my_slot && !cfg_err_r) begin
               st_nxt = ST_RTS;
            end
         end
         ST_RTS: begin
            if (cts_s_r) begin
               st_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            if (tx_go && txl_r) begin
               st_nxt = ST_RESP;
            end
         end
         ST_RESP: begin
            if (resp_hit) begin
               ok_nxt = 1'b1;
               st_nxt = ST_IDLE;
            end else if (my_slot) begin
               to_nxt = 1'b1;
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= ST_IDLE;
         txv_r <= 1'b0;
         txd_r <= BYTE_RST;
         txl_r <= 1'b0;
         ok_r <= 1'b0;
         to_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         txv_r <= txv_nxt;
         txd_r <= txd_nxt;
         txl_r <= txl_nxt;
         ok_r <= ok_nxt;
         to_r <= to_nxt;
      end
   end

   assign o_rts = (st_r == ST_RTS) || (st_r == ST_SEND);
   assign o_tx_valid = txv_r;
   assign o_tx_data = txd_r;
   assign o_tx_last = txl_r;
   assign o_resp_ok = ok_r;
   assign o_resp_timeout = to_r;
   assign o_cfg_err = cfg_err_r;
   assign o_slice_warn = warn_r;
   assign o_slot = slot;

   // -----------------------------------------------------------------
   // Driver and receiver enables
   // -----------------------------------------------------------------
   assign sending = (st_r == ST_SEND);

   always_comb begin
      unique case (i_drv_mode)
         MLA_HALF_DUPLEX_DRIVER: begin
            o_tx_drv_en = 1'b1;
            o_rx_en = !sending;
         end
         MLA_TWO_WIRE_DRIVER: begin
            o_tx_drv_en = cts_s_r;
            o_rx_en = !sending;
         end
         default: begin
            o_tx_drv_en = 1'b1;
            o_rx_en = 1'b1;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Receive monitor and forwarding
   // -----------------------------------------------------------------
   assign rx_acc = i_rx_valid && o_rx_en;

   always_comb begin
      pos_nxt = pos_r;
      match_nxt = match_r;
      fv_nxt = 1'b0;
      fd_nxt = fd_r;
      fl_nxt = fl_r;
      hop_nxt = hop_r;
      resp_hit = 1'b0;
      if (rx_acc) begin
         if (pos_r == POS_ADDR) begin
            match_nxt = (i_rx_data == i_node_addr);
            pos_nxt = POS_HOP;
            resp_hit = match_nxt && i_rx_last;
         end else begin
            if (match_r) begin
               fv_nxt = 1'b1;
               fd_nxt = i_rx_data;
               fl_nxt = i_rx_last;
               if (pos_r == POS_HOP) begin
                  hop_nxt = i_rx_data;
               end
            end
            pos_nxt = POS_DATA;
            resp_hit = match_r && i_rx_last;
         end
         if (i_rx_last) begin
            pos_nxt = POS_ADDR;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pos_r <= POS_ADDR;
         match_r <= 1'b0;
         fv_r <= 1'b0;
         fd_r <= BYTE_RST;
         fl_r <= 1'b0;
         hop_r <= BYTE_RST;
      end else begin
         pos_r <= pos_nxt;
         match_r <= match_nxt;
         fv_r <= fv_nxt;
         fd_r <= fd_nxt;
         fl_r <= fl_nxt;
         hop_r <= hop_nxt;
      end
   end

   assign o_fwd_valid = fv_r;
   assign o_fwd_data = fd_r;
   assign o_fwd_last = fl_r;
   assign o_fwd_hop = hop_r;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   a_rts_own_slot: assert property ($rose(o_rts) |-> $past(my_slot) && !$past(cfg_err_r))
      else $error("RTS rose outside own slot.");
   a_slot_range: assert property (slot_start && !cfg_err_r
      |-> slot >= PRIO_MIN && slot <= i_node_count)
      else $error("Slot index out of range.");
   a_cts_gate: assert property (st_r == ST_RTS && !cts_s_r |=> st_r != ST_SEND)
      else $error("Send began without CTS.");
   a_tx_under_rts: assert property (o_tx_valid |-> o_rts)
      else $error("Data offered without RTS.");
   a_resp_wait: assert property (st_r == ST_SEND && tx_go && txl_r
      |=> st_r == ST_RESP && !o_rts)
      else $error("No response wait after last byte.");
   a_cfg_block: assert property (st_r == ST_IDLE && cfg_err_r |=> st_r == ST_IDLE)
      else $error("Transmit started with bad priority.");
   a_ptp_enables: assert property (i_drv_mode == MLA_POINT_TO_POINT_DRIVER
      |-> o_tx_drv_en && o_rx_en)
      else $error("Point to point enables wrong.");
   a_half_rx_off: assert property (i_drv_mode == MLA_HALF_DUPLEX_DRIVER && sending
      |-> o_tx_drv_en && !o_rx_en)
      else $error("Half duplex enables wrong.");
   a_two_wire_cts: assert property (i_drv_mode == MLA_TWO_WIRE_DRIVER
      |-> o_tx_drv_en == $past(i_cts, 2) && (sending == !o_rx_en))
      else $error("Two wire enables wrong.");
   a_echo_ignored: assert property (i_rx_valid && !o_rx_en |=> !o_fwd_valid)
      else $error("Byte taken while receiver off.");
   a_fwd_match: assert property (o_fwd_valid
      |-> $past(rx_acc) && $past(match_r) && o_fwd_data == $past(i_rx_data))
      else $error("Forwarded a byte not addressed here.");

   c_rts_raise: cover property ($rose(o_rts));
   c_resp_ok: cover property (o_resp_ok);
   c_resp_timeout: cover property (o_resp_timeout);
   c_fwd_end: cover property (o_fwd_valid && o_fwd_last);
endmodule : mla_multidrop_line_arbiter
`default_nettype wire

// >>> tb/mla_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module mla_line_model #(
   parameter int CTS_DLY = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_rts,
   output logic o_cts,
   output logic o_tx_ready
);
   logic [3:0] cnt_r;
   // CTS answers RTS after a delay and falls as soon as RTS falls.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_r <= 4'h0;
         o_cts <= 1'b0;
         o_tx_ready <= 1'b0;
      end else begin
         o_tx_ready <= ~o_tx_ready;
         if (!i_rts) begin
            cnt_r <= 4'h0;
            o_cts <= 1'b0;
         end else if (cnt_r == CTS_DLY[3:0]) begin
            o_cts <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule : mla_line_model
`default_nettype wire

// >>> tb/mla_multidrop_line_arbiter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mla_multidrop_line_arbiter_tb;
   import mla_pkg::*;
   logic clk, nrst, cts, rts, drv, rxe, pv, pl, pr, tv, tl, txr, rv, rl, fv, fl, rok, rto;
   logic cerr, swarn;
   logic [7:0] addr, cnt, prio, slice, pd, td, rd, fd, fhop, slot;
   logic [1:0] mode;
   int miscompares, checks_done;

   mla_multidrop_line_arbiter #(.TICK_CYC(10)) mla_multidrop_line_arbiter_i (
      .i_sys_clk(clk), .i_nrst(nrst), .i_node_addr(addr), .i_node_count(cnt),
      .i_node_prio(prio), .i_time_slice(slice), .i_drv_mode(mode), .i_cts(cts),
      .o_rts(rts), .o_tx_drv_en(drv), .o_rx_en(rxe), .i_pkt_valid(pv), .i_pkt_data(pd),
      .i_pkt_last(pl), .o_pkt_ready(pr), .o_tx_valid(tv), .o_tx_data(td), .o_tx_last(tl),
      .i_tx_ready(txr), .i_rx_valid(rv), .i_rx_data(rd), .i_rx_last(rl), .o_fwd_valid(fv),
      .o_fwd_data(fd), .o_fwd_last(fl), .o_fwd_hop(fhop), .o_resp_ok(rok),
      .o_resp_timeout(rto), .o_cfg_err(cerr), .o_slice_warn(swarn), .o_slot(slot));

   mla_line_model mla_line_model_i (.i_sys_clk(clk), .i_nrst(nrst), .i_rts(rts),
      .o_cts(cts), .o_tx_ready(txr));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task step;
      @(posedge clk);
      #10;
   endtask : step

   task conclude;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task t_slots;
      int n;
      logic [7:0] s;
      chk(slot, 8'h00);
      for (int k = 0; k < 5; k++) begin
         s = slot;
         n = 0;
         while (slot === s && n < 200) begin
            step;
            n++;
         end
         chk(slot, (s % cnt) + 8'h01);
         if (k > 0) chk(n[7:0], 8'h32);
      end
      $display("test slots done");
   endtask : t_slots

   task t_cfg;
      prio = 8'h04;
      pv = 1'b1;
      pd = 8'h21;
      step;
      step;
      chk(cerr, 1'b1);
      repeat (160) begin
         step;
         chk(rts, 1'b0);
      end
      prio = 8'h00;
      step;
      step;
      chk(cerr, 1'b1);
      prio = 8'h02;
      pv = 1'b0;
      step;
      step;
      chk(cerr, 1'b0);
      slice = 8'h04;
      step;
      step;
      chk(swarn, 1'b1);
      slice = 8'h05;
      step;
      step;
      chk(swarn, 1'b0);
      $display("test cfg done");
   endtask : t_cfg

   task t_send(input logic [1:0] m);
      logic [7:0] msg [3];
      int pk, tk, n;
      logic up, echo;
      msg = '{8'h21, 8'hA1, 8'hA2};
      pk = 0;
      tk = 0;
      n = 0;
      up = 1'b0;
      mode = m;
      pv = 1'b1;
      pd = msg[0];
      pl = 1'b0;
      rd = addr;
      step;
      chk(drv, m != 2'h2);
      chk(rxe, 1'b1);
      while (tk < 3 && n < 600) begin
         @(negedge clk);
         if (rts && !up) begin
            up = 1'b1;
            chk(slot, prio);
         end
         if (tv) begin
            chk(cts, 1'b1);
            chk(rxe, m == 2'h0);
            chk(drv, 1'b1);
         end
         if (tv && txr) begin
            chk(td, msg[tk]);
            chk(tl, tk == 2);
            tk++;
         end
         if (pv && pr) pk++;
         echo = tv && !tl && (m != 2'h0);
         chk(fv, 1'b0);
         step;
         rv = echo;
         if (pk < 3) begin
            pd = msg[pk];
            pl = (pk == 2);
         end else begin
            pv = 1'b0;
         end
         n++;
      end
      step;
      chk(rts, 1'b0);
      chk(tk[7:0], 8'h03);
      $display("test send done");
   endtask : t_send

   task rx_pkt(input logic [7:0] a, h, d, input logic ef, er);
      rv = 1'b1;
      rd = a;
      step;
      rd = h;
      @(negedge clk);
      chk(fv, 1'b0);
      step;
      rd = d;
      rl = 1'b1;
      @(negedge clk);
      chk(fv, ef);
      if (ef) chk(fhop, h);
      if (ef) chk(fl, 1'b0);
      step;
      rv = 1'b0;
      rl = 1'b0;
      @(negedge clk);
      chk(fv, ef);
      chk(rok, er);
      if (ef) chk(fd, d);
      if (ef) chk(fl, 1'b1);
      step;
      $display("test receive done");
   endtask : rx_pkt

   task t_timeout;
      int n;
      n = 0;
      while (rto !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(rto, 1'b1);
      chk(slot, prio);
      $display("test timeout done");
   endtask : t_timeout

   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #(20000 * 100);
      miscompares++;
      conclude;
   end

   initial begin
      nrst = 1'b0;
      addr = 8'h12;
      cnt = 8'h03;
      prio = 8'h02;
      slice = 8'h05;
      mode = 2'h0;
      {pv, pd, pl, rv, rd, rl} = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      #10;
      chk(rts, 1'b0);
      chk(cerr, 1'b1);
      nrst = 1'b1;
      t_slots;
      t_cfg;
      t_send(2'h0);
      rx_pkt(8'h12, 8'h07, 8'h5A, 1'b1, 1'b1);
      rx_pkt(8'h33, 8'h44, 8'h55, 1'b0, 1'b0);
      t_send(2'h1);
      rx_pkt(8'h12, 8'h09, 8'hC3, 1'b1, 1'b1);
      t_send(2'h2);
      t_timeout;
      conclude;
   end
endmodule : mla_multidrop_line_arbiter_tb
`default_nettype wire
